// ### spces_defs.vh
/*
  spces_defs.vh: constants for the serial port clock edge select block.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef SPCES_DEFS_VH
`define SPCES_DEFS_VH

// pin filter vector bit positions
`define SPCES_PIN_IOCLK   0
`define SPCES_PIN_CSN     1
`define SPCES_PIN_FS      2
`define SPCES_PIN_DIN     3
`define SPCES_PIN_INVN    4
`define SPCES_PIN_CNT     5
// filtered pin levels out of reset: clock low, chip select idle high,
// clock-invert strap high (not inverted)
`define SPCES_PIN_RST     5'h12

// interface mode flag values
`define SPCES_MODE_MP     1'b1
`define SPCES_MODE_DSP    1'b0
`define SPCES_MODE_RST    1'b1

// default word widths of the input and output shift registers
`define SPCES_RX_W        10
`define SPCES_TX_W        10

`endif

// ### spces_buf.v
/*
  spces_buf.v: two-entry buffer with valid/ready on both sides.
  Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps

module spces_buf #(
  parameter W     = 10,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // fill side
  input  wire         in_valid_i,
  output reg          in_ready_o,
  input  wire [W-1:0] in_data_i,
  // drain side
  output reg          out_valid_o,
  input  wire         out_ready_i,
  output reg  [W-1:0] out_data_o
);

  localparam [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

  reg [W-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   cnt_reg;
  wire         push;
  wire         pop;
  wire [AW:0]  cnt_next;
  wire [AW-1:0] rd_ptr_next;

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign cnt_next    = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign rd_ptr_next = pop ? rd_ptr_reg + PTR_ONE[AW-1:0] : rd_ptr_reg;

  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg  <= {AW{1'b0}};
      rd_ptr_reg  <= {AW{1'b0}};
      cnt_reg     <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
      out_data_o  <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_ONE[AW-1:0];
      end
      rd_ptr_reg  <= rd_ptr_next;
      cnt_reg     <= cnt_next;
      in_ready_o  <= (cnt_next != DEPTH[AW:0]);
      out_valid_o <= (cnt_next != {(AW+1){1'b0}});
      // registered head; a word written this cycle into an empty buffer
      // goes straight to the head
      if (cnt_reg == {(AW+1){1'b0}} || (pop && cnt_reg == {{AW{1'b0}}, 1'b1})) begin
        out_data_o <= in_data_i;
      end else if (pop) begin
        out_data_o <= mem_reg[rd_ptr_next];
      end
    end
  end

endmodule // spces_buf

// ### spces_port.v
/*
  spces_port.v: serial host port of the converter, selecting which edge of
  the host-driven I/O clock samples input data and which changes output.
  Assumes all serial pins arrive asynchronously from the host and that the
  I/O clock is well below a quarter of clk_i (filter needs stable levels).
*/
//
// Behaviour
// - Incoming serial bits are shifted in on edges of the host's I/O clock.
// - With clock invert held low the input sampling edge is inverted.
// - With inverted sampling, output bits change on the sampling edge.
// - Frame sync high at chip-select fall picks microprocessor mode, low DSP mode.
// - The mode and clock invert pick rising or falling edges per the edge table.
`timescale 1ns/1ps
`include "spces_defs.vh"

module spces_port #(
  parameter RX_W = `SPCES_RX_W,
  parameter TX_W = `SPCES_TX_W
) (
  // clock and reset
  input  wire            clk_i,
  input  wire            rst_n_i,
  // host serial pins
  input  wire            io_clk_i,
  input  wire            cs_n_i,
  input  wire            frame_sync_in_i,
  input  wire            data_in_i,
  input  wire            clock_invert_select_n_i,
  output reg             data_out_o,
  output reg             data_out_oe_o,
  // status
  output reg             host_processor_mode_o,
  output reg             rx_overrun_o,
  // word to send, taken at chip-select fall
  input  wire [TX_W-1:0] tx_data_i,
  // received words
  output wire            rx_valid_o,
  input  wire            rx_ready_i,
  output wire [RX_W-1:0] rx_data_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin filters: three stages, a change counts when stages two and three agree
  // costs four clk of latency on every pin, so each io_clk phase must
  // last at least four clk
  localparam [`SPCES_PIN_CNT-1:0] PIN_RST = `SPCES_PIN_RST;

  wire [`SPCES_PIN_CNT-1:0] pin_raw;
  wire [`SPCES_PIN_CNT-1:0] pin_lvl;

  assign pin_raw = {clock_invert_select_n_i, data_in_i, frame_sync_in_i,
                    cs_n_i, io_clk_i};

  genvar g;
  generate
    for (g = 0; g < `SPCES_PIN_CNT; g = g + 1) begin : g_pin
      reg [2:0] sh_reg;
      reg       lvl_reg;
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sh_reg  <= {3{PIN_RST[g]}};
          lvl_reg <= PIN_RST[g];
        end else begin
          sh_reg <= {sh_reg[1:0], pin_raw[g]};
          if (sh_reg[2] == sh_reg[1]) begin
            lvl_reg <= sh_reg[2];
          end
        end
      end
      assign pin_lvl[g] = lvl_reg;
    end
  endgenerate

  wire io_clk_lvl = pin_lvl[`SPCES_PIN_IOCLK];
  wire cs_n_lvl   = pin_lvl[`SPCES_PIN_CSN];
  wire fs_lvl     = pin_lvl[`SPCES_PIN_FS];
  wire din_lvl    = pin_lvl[`SPCES_PIN_DIN];
  wire inv_n_lvl  = pin_lvl[`SPCES_PIN_INVN];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the filtered levels
  // previous levels reset to the idle pin levels: no false edge after reset
  reg io_clk_prev_reg;
  reg cs_n_prev_reg;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_clk_prev_reg <= PIN_RST[`SPCES_PIN_IOCLK];
      cs_n_prev_reg   <= PIN_RST[`SPCES_PIN_CSN];
    end else begin
      io_clk_prev_reg <= io_clk_lvl;
      cs_n_prev_reg   <= cs_n_lvl;
    end
  end

  wire clk_rise = io_clk_lvl & ~io_clk_prev_reg;
  wire clk_fall = ~io_clk_lvl & io_clk_prev_reg;
  wire cs_fall  = ~cs_n_lvl & cs_n_prev_reg;
  wire cs_rise  = cs_n_lvl & ~cs_n_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // mode capture; frame sync is only looked at on chip-select fall
  reg mode_reg;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= `SPCES_MODE_RST;
    end else if (cs_fall) begin
      mode_reg <= fs_lvl ? `SPCES_MODE_MP : `SPCES_MODE_DSP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge selection; mode used is the value live at this cs fall
  wire mode_now   = cs_fall ? fs_lvl : mode_reg;
  // sampling edge per mode and strap; a low strap swaps it
  reg samp_rise;

  always @* begin
    case ({mode_now, inv_n_lvl})
      2'b11:   samp_rise = 1'b1;
      2'b01:   samp_rise = 1'b0;
      2'b10:   samp_rise = 1'b0;
      2'b00:   samp_rise = 1'b1;
      default: samp_rise = 1'b0;
    endcase
  end
  // output edge ignores the invert strap, so it lands on the sampling edge
  // exactly when sampling is inverted
  wire out_rise   = (mode_now == `SPCES_MODE_DSP);
  // edges in the cs-fall cycle are dropped: mode and count not yet settled
  wire active     = ~cs_n_lvl & ~cs_fall;
  wire samp_edge  = active & (samp_rise ? clk_rise : clk_fall);
  wire out_edge   = active & (out_rise ? clk_rise : clk_fall);

  ////////////////////////////////////////////////////////////////////////////
  // input shift register and word assembly
  localparam CW = $clog2(RX_W + 1);
  localparam integer  RX_LAST_I = RX_W - 1;
  localparam [CW-1:0] RX_LAST   = RX_LAST_I[CW-1:0];
  // a partial word at chip-select rise is dropped: count restarts at next fall

  reg  [RX_W-1:0] rx_sh_reg;
  reg  [CW-1:0]   rx_cnt_reg;
  reg  [RX_W-1:0] rx_word_reg;
  reg             rx_pend_reg;
  wire            buf_ready;
  wire [RX_W-1:0] rx_sh_next = {rx_sh_reg[RX_W-2:0], din_lvl};
  wire            word_done  = samp_edge & (rx_cnt_reg == RX_LAST);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sh_reg    <= {RX_W{1'b0}};
      rx_cnt_reg   <= {CW{1'b0}};
      rx_word_reg  <= {RX_W{1'b0}};
      rx_pend_reg  <= 1'b0;
      rx_overrun_o <= 1'b0;
    end else begin
      if (cs_fall) begin
        rx_cnt_reg <= {CW{1'b0}};
      end else if (samp_edge) begin
        rx_sh_reg  <= rx_sh_next;
        rx_cnt_reg <= word_done ? {CW{1'b0}} : rx_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end
      // held word waits for the buffer; a new word then overwrites it
      if (word_done) begin
        rx_word_reg  <= rx_sh_next;
        rx_pend_reg  <= 1'b1;
        rx_overrun_o <= rx_pend_reg & ~buf_ready;
      end else if (rx_pend_reg & buf_ready) begin
        rx_pend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output shift register; first bit is on the pin from chip-select fall
  // past the last bit zeros shift out until chip select rises
  reg [TX_W-1:0] tx_sh_reg;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sh_reg             <= {TX_W{1'b0}};
      data_out_o            <= 1'b0;
      data_out_oe_o         <= 1'b0;
      host_processor_mode_o <= `SPCES_MODE_RST;
    end else begin
      host_processor_mode_o <= mode_now;
      data_out_oe_o         <= ~cs_n_lvl & ~cs_rise;
      if (cs_fall) begin
        tx_sh_reg  <= tx_data_i;
        data_out_o <= tx_data_i[TX_W-1];
      end else if (out_edge) begin
        tx_sh_reg  <= {tx_sh_reg[TX_W-2:0], 1'b0};
        data_out_o <= tx_sh_reg[TX_W-2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer absorbs a stall of the reader; a word is lost only when both
  // entries and the hold register are full, which raises the overrun flag
  // at the next word completion
  spces_buf #(
    .W     (RX_W),
    .DEPTH (2),
    .AW    (1)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rx_pend_reg),
    .in_ready_o  (buf_ready),
    .in_data_i   (rx_word_reg),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

endmodule // spces_port

// ### spces_port_sva.sv
/* spces_port_sva.sv: edge, mode and enable checker for spces_port.
   Assumes io_clk phases of at least 4 clk and the pin delay of the port. */
`timescale 1ns/1ps
module spces_port_chk (
  // watched ports
  input wire clk_i,
  input wire rst_n_i,
  input wire io_clk_i,
  input wire cs_n_i,
  input wire frame_sync_in_i,
  input wire data_out_o,
  input wire data_out_oe_o,
  input wire host_processor_mode_o
);
  reg [3:0] low_cnt;
  reg [6:0] ck_h;
  // io_clk history spans the pin delay, one clk slack either way
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 4'h0;
      ck_h    <= 7'h00;
    end else begin
      low_cnt <= cs_n_i ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hf};
      ck_h    <= {ck_h[5:0], io_clk_i};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_mode_from_fs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    low_cnt == 4'h8 |-> host_processor_mode_o == $past(frame_sync_in_i, 6))
    else $error("mode differs from frame sync at select");
  a_mode_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(host_processor_mode_o) |-> low_cnt inside {[4'h3:4'h7]})
    else $error("mode changed away from select fall");
  a_dout_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(data_out_o) && low_cnt > 4'h7 |->
    (host_processor_mode_o ? ck_h[6] && !ck_h[3] : !ck_h[6] && ck_h[3]))
    else $error("output bit moved on the wrong clock edge");
  a_oe_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(data_out_oe_o) |-> low_cnt inside {[4'h3:4'h7]})
    else $error("output enable rose without select");
  a_oe_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(data_out_oe_o) |-> $past(cs_n_i, 4))
    else $error("output enable fell while selected");
  a_oe_sel_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    low_cnt > 4'h5 |-> data_out_oe_o)
    else $error("output enable low while selected");
endmodule // spces_port_chk

bind spces_port spces_port_chk i_spces_port_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .io_clk_i(io_clk_i), .cs_n_i(cs_n_i), .frame_sync_in_i(frame_sync_in_i),
  .data_out_o(data_out_o), .data_out_oe_o(data_out_oe_o),
  .host_processor_mode_o(host_processor_mode_o));

// ### spces_host.sv
/* spces_host.sv: host serial port model driving io_clk, select, frame sync.
   Assumes a 160 ns io_clk that idles low between frames. */
`timescale 1ns/1ps
module spces_host (
  // pins toward the port
  output reg  io_clk_o,
  output reg  cs_n_o,
  output reg  fs_o,
  output reg  din_o,
  input  wire dout_i
);
  initial begin
    io_clk_o = 1'b0;
    cs_n_o   = 1'b1;
    fs_o     = 1'b0;
    din_o    = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input mp, input inv_n, input [9:0] wr, output [9:0] rd);
    integer h;
    integer si;
    reg     smp;
    begin
      si  = 0;
      smp = 1'b0;
      fs_o = 1'b1;
      #160;
      fs_o = mp;
      #80;
      cs_n_o = 1'b0;
      din_o  = wr[9];
      // first output bit must pass the pin delay before the first dsp read
      #80;
      for (h = 0; h < 20; h = h + 1) begin
        #40;
        if (h == 2) fs_o = 1'b0;
        // new bit only after the sampling edge, so a wrong edge sees a shift
        if (smp && si < 10) din_o = wr[9-si];
        if (io_clk_o == mp) rd = {rd[8:0], dout_i};
        smp = (io_clk_o == (mp ^ inv_n));
        #40;
        io_clk_o = ~io_clk_o;
        if (smp) si = si + 1;
      end
      #80;
      cs_n_o = 1'b1;
      din_o  = ~din_o;
      #160;
    end
  endtask
endmodule // spces_host

// ### spces_port_tb_top.sv
/* spces_port_tb_top.sv: self-checking bench for spces_port.
   Assumes spces_host on the pins and the checker bound in. */
`timescale 1ns/1ps
module spces_port_tb_top;
  reg        clk_i;
  reg        rst_n_i;
  reg        inv_n;
  reg        rx_ready;
  reg  [9:0] tx_data;
  wire       io_clk, cs_n, fs, din, dout, oe, mode, ovr, rx_valid;
  wire [9:0] rx_data;
  integer    errors;
  integer    samples_checked;
  spces_host i_spces_host (.io_clk_o(io_clk), .cs_n_o(cs_n), .fs_o(fs), .din_o(din),
    .dout_i(dout));
  spces_port i_spces_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_clk_i(io_clk),
    .cs_n_i(cs_n), .frame_sync_in_i(fs), .data_in_i(din),
    .clock_invert_select_n_i(inv_n), .data_out_o(dout), .data_out_oe_o(oe),
    .host_processor_mode_o(mode), .rx_overrun_o(ovr), .tx_data_i(tx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task chk(input [9:0] got, input [9:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task take(input [9:0] exp);
    integer n;
    begin
      n = 0;
      while (rx_valid !== 1'b1 && n < 200) begin
        @(posedge clk_i);
        #1;
        n = n + 1;
      end
      if (rx_valid !== 1'b1) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, rx_valid, 1'b1);
        complete_run;
      end
      chk(rx_data, exp);
      rx_ready = 1'b1;
      @(posedge clk_i);
      #1;
      rx_ready = 1'b0;
      // idle edge so a following take never re-raises ready at once
      @(posedge clk_i);
      #1;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // all four strap and mode pairs, distinct words both ways
  task s_edges;
    integer   k;
    reg [9:0] w;
    reg [9:0] rd;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        w = 10'h2c5 ^ {k[1:0], 8'h3c};
        @(posedge clk_i);
        #1;
        inv_n   = k[0];
        tx_data = ~w;
        i_spces_host.xfer(k[1], k[0], w, rd);
        chk({9'h000, mode}, {9'h000, k[1]});
        chk(rd, ~w);
        take(w);
      end
    end
  endtask
  // reader stalls: two entries and the hold register fill, fourth overwrites
  task s_buffer;
    reg [9:0] rd;
    begin
      @(posedge clk_i);
      #1;
      inv_n = 1'b1;
      i_spces_host.xfer(1'b1, 1'b1, 10'h001, rd);
      i_spces_host.xfer(1'b1, 1'b1, 10'h3fe, rd);
      i_spces_host.xfer(1'b1, 1'b1, 10'h2aa, rd);
      chk({9'h000, ovr}, 10'h000);
      i_spces_host.xfer(1'b1, 1'b1, 10'h155, rd);
      chk({9'h000, ovr}, 10'h001);
      take(10'h001);
      take(10'h3fe);
      take(10'h155);
    end
  endtask
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_n_i  = 1'b0;
    inv_n    = 1'b1;
    rx_ready = 1'b0;
    tx_data  = 10'h000;
    repeat (5) @(posedge clk_i);
    #1;
    chk({9'h000, mode}, 10'h001);
    rst_n_i = 1'b1;
    s_edges;
    s_buffer;
    complete_run;
  end
endmodule // spces_port_tb_top
